/* File: design/xpt_parallel_prog.sv */
// Parallel programming logic with first and second rank route latches
//
// Behaviour
// - One write/update cycle reprograms one or more outputs and leaves all others alone.
// - The reset pin disables every output but clears no programming storage.
// - Bit 4 of each entry is the output enable; a disabled entry ignores its input select.
// - A falling write strobe captures address and data into the addressed first-rank entry.
// - First-rank entries reach the matrix only when update goes low, all together.
// - With serial/parallel low and serial clock high, a strobe loads every entry at once.
// - While update is low the second rank passes first-rank contents straight through.
// - The first rank holds one five-bit entry for each of the nine outputs.
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`default_nettype none
module xpt_parallel_prog
  import xpt_prog_pkg::*;
#(
  parameter int unsigned OUTPUTS = NUM_OUTPUTS
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  input  wire logic                     chip_select_n,
  input  wire logic                     serial_parallel_select,
  input  wire logic                     serial_clk_n,
  input  wire logic                     write_strobe_n,
  input  wire logic [ADDR_W-1:0]        output_address,
  input  wire logic                     output_enable_bit,
  input  wire logic [SEL_W-1:0]         input_select,
  input  wire logic                     update_n,
  input  wire logic                     pin_reset_n,
  output logic [OUTPUTS-1:0]            route_enable,
  output logic [OUTPUTS*SEL_W-1:0]      route_select
);
  logic [ENTRY_W-1:0] rank1_r [OUTPUTS];
  logic [ENTRY_W-1:0] rank2_r [OUTPUTS];
  logic [1:0]         ctrl_r;
  logic [ADDR_W-1:0]  last_addr_r;
  logic [CNT_W-1:0]   wr_count_r;
  logic               we_fell;
  logic               strobe;
  logic               par_wr;
  logic               bcast_wr;
  logic               upd_active;
  logic               addr_ok;
  logic [ENTRY_W-1:0] wr_entry;
  logic [7:0]         rd_addr;
  logic [31:0]        rd_value;
  logic               reg_wr;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;

  // Register index of an entry readback address, or OUTPUTS if none matches
  // Shared by the read mux; a miss returns an index that no entry owns
  function automatic int unsigned entry_index(input logic [7:0] a);
    int unsigned idx;
    idx = OUTPUTS;
    for (int unsigned k = 0; k < OUTPUTS; k++) begin
      if (a == ENTRY0_OFS + 8'(4 * k)) begin
        idx = k;
      end
    end
    return idx;
  endfunction

  xpt_fall_detect u_we_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .level_n (write_strobe_n),
    .fell    (we_fell)
  );

  xpt_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_value  (rd_value),
    .reg_wr    (reg_wr),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata)
  );

  // Strobe decode; chip select gates the pins, software may lock them out
  // Edge detection adds no cycle (fell is combinational from the pin) and keeps the strobe pin off any clock
  assign strobe   = we_fell & ~chip_select_n & ctrl_r[CTRL_ACCEPT_POS];
  assign addr_ok  = 32'(output_address) < OUTPUTS;
  assign par_wr   = strobe & serial_parallel_select & addr_ok;
  assign bcast_wr = strobe & ~serial_parallel_select & serial_clk_n;
  assign wr_entry = {output_enable_bit, input_select};

  // Update is level sensitive; select gates it like the serial clock
  // Freeze lets software stage several changes with no partial matrix
  assign upd_active = ~update_n & ~chip_select_n & ~ctrl_r[CTRL_FREEZE_POS];

  // Software control register
  // Accept gates pin writes, freeze holds the matrix latches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (reg_wr && reg_addr == CTRL_OFS) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end

  // Write bookkeeping for status readback
  // The count wraps silently; it is a debug aid, not a guarantee
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_addr_r <= '0;
      wr_count_r  <= '0;
    end else if (par_wr || bcast_wr) begin
      last_addr_r <= output_address;
      wr_count_r  <= wr_count_r + CNT_W'(1);
    end
  end

  // The second rank is clocked rather than a true latch: one cycle of latency
  // buys storage with no level-sensitive paths. A change of update can
  // therefore only reach the outputs on a clock edge.
  genvar gi;
  generate
    for (gi = 0; gi < OUTPUTS; gi++) begin : g_out
      // First rank has no reset: contents are random after power-up by design
      always_ff @(posedge hclk) begin
        if (bcast_wr || (par_wr && 32'(output_address) == gi)) begin
          rank1_r[gi] <= wr_entry;
        end
      end

      // Second rank follows the first only while update is low
      always_ff @(posedge hclk) begin
        if (upd_active) begin
          rank2_r[gi] <= rank1_r[gi];
        end
      end

      // Driven outputs; the pin reset only disables, storage is untouched
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          route_enable[gi]                 <= 1'b0;
          route_select[gi*SEL_W +: SEL_W]  <= '0;
        end else begin
          route_enable[gi] <= pin_reset_n & rank2_r[gi][ENABLE_POS];
          route_select[gi*SEL_W +: SEL_W] <=
            rank2_r[gi][ENABLE_POS] ? rank2_r[gi][SEL_W-1:0] : '0;
        end
      end

      AST_CAPTURE_ADDRESSED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        par_wr && 32'(output_address) == gi
        |=> rank1_r[gi] == {$past(output_enable_bit), $past(input_select)})
        else $error("addressed entry did not capture the strobed data");

      AST_OTHERS_UNCHANGED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !bcast_wr && !(par_wr && 32'(output_address) == gi) |=> $stable(rank1_r[gi]))
        else $error("entry changed without being addressed");

      AST_BROADCAST_ALL: assert property (
        @(posedge hclk) disable iff (!hresetn)
        bcast_wr |=> rank1_r[gi] == $past(wr_entry))
        else $error("broadcast did not load every entry");

      AST_HOLD_UNTIL_UPDATE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !upd_active |=> $stable(rank2_r[gi]))
        else $error("matrix latch moved while update was high");

      AST_TRANSPARENT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        upd_active ##1 upd_active |=> rank2_r[gi] == $past(rank1_r[gi]))
        else $error("matrix latch not transparent while update low");

      AST_RESET_DISABLES: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pin_reset_n |=> !route_enable[gi] && ($stable(rank1_r[gi]) || $past(strobe)))
        else $error("pin reset did not disable the output");

      AST_SELECT_IGNORED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !rank2_r[gi][ENABLE_POS] |=> route_select[gi*SEL_W +: SEL_W] == '0)
        else $error("disabled output carries an input select");

      AST_MATRIX_PATH: assert property (
        @(posedge hclk) disable iff (!hresetn)
        pin_reset_n ##1 pin_reset_n |-> route_enable[gi] == $past(rank2_r[gi][ENABLE_POS]))
        else $error("output enable does not follow the matrix latch");

      // Storage holds unknowns until first written, so these checks rely on
      // antecedents that only hold once the controller has programmed it;
      // gating checks cover lock-out, deselect and freeze
      AST_TRANSPARENT_STEP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        upd_active |=> rank2_r[gi] == $past(rank1_r[gi]))
        else $error("matrix latch missed a first-rank value while update low");

      AST_SELECT_FOLLOWS: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rank2_r[gi][ENABLE_POS]
        |=> route_select[gi*SEL_W +: SEL_W] == $past(rank2_r[gi][SEL_W-1:0]))
        else $error("enabled output does not carry its input select");

      AST_DISABLED_ROUTE_OFF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !rank2_r[gi][ENABLE_POS] |=> !route_enable[gi])
        else $error("disabled matrix entry left its output enabled");

      AST_RESET_KEEPS_MATRIX: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !pin_reset_n |=> $stable(rank2_r[gi]) || $past(upd_active))
        else $error("pin reset disturbed the matrix latch");

      AST_LOCKED_OUT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !ctrl_r[CTRL_ACCEPT_POS] |=> $stable(rank1_r[gi]))
        else $error("pin write landed while software locked the pins out");

      AST_WRITE_NEEDS_SELECT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chip_select_n |=> $stable(rank1_r[gi]))
        else $error("pin write landed with chip select high");

      AST_DESELECTED_HOLD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chip_select_n |=> $stable(rank2_r[gi]))
        else $error("matrix latch moved with chip select high");

      AST_FROZEN_HOLD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ctrl_r[CTRL_FREEZE_POS] |=> $stable(rank2_r[gi]))
        else $error("matrix latch moved while software froze update");

      AST_OUT_OF_RANGE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        strobe && serial_parallel_select && 32'(output_address) >= OUTPUTS
        |=> $stable(rank1_r[gi]))
        else $error("write to unimplemented output changed an entry");
    end
  endgenerate

  // Bookkeeping checks; every accepted fall gives at most one capture
  // and the status fields follow the captures that really landed
  AST_STROBE_PULSE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    strobe |=> !strobe)
    else $error("one strobe fall was taken more than once");

  AST_COUNT_STEP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    par_wr || bcast_wr |=> wr_count_r == $past(wr_count_r) + CNT_W'(1))
    else $error("write count did not advance on a capture");

  AST_LAST_ADDR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    par_wr || bcast_wr |=> last_addr_r == $past(output_address))
    else $error("status address does not hold the last captured output");

  // Read mux; unmapped addresses read as zero
  // Entry words show both ranks so software can see staged data
  always_comb begin
    int unsigned idx;
    idx      = entry_index(rd_addr);
    rd_value = 32'h0000_0000;
    if (rd_addr == CTRL_OFS) begin
      rd_value[1:0] = ctrl_r;
    end else if (rd_addr == STATUS_OFS) begin
      rd_value[STAT_PINRST_POS]                 = ~pin_reset_n;
      rd_value[STAT_UPD_POS]                    = upd_active;
      rd_value[STAT_BCAST_POS]                  = ~serial_parallel_select;
      rd_value[STAT_ADDR_LSB +: ADDR_W]         = last_addr_r;
      rd_value[STAT_CNT_LSB +: CNT_W]           = wr_count_r;
    end else if (rd_addr == ENABLES_OFS) begin
      rd_value[OUTPUTS-1:0] = route_enable;
    end else if (idx < OUTPUTS) begin
      rd_value[ENTRY_W-1:0]                     = rank1_r[idx];
      rd_value[ENTRY_RANK2_LSB +: ENTRY_W]      = rank2_r[idx];
    end
  end
endmodule // xpt_parallel_prog
`default_nettype wire

/* File: design/xpt_prog_pkg.sv */
// Shared constants for the crosspoint parallel programming block
`default_nettype none
package xpt_prog_pkg;
  // Matrix geometry
  localparam int unsigned NUM_OUTPUTS = 9;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned SEL_W       = 4;
  localparam int unsigned ENTRY_W     = 5;
  localparam int unsigned ENABLE_POS  = 4;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] ENABLES_OFS  = 8'h08;
  localparam logic [7:0] ENTRY0_OFS   = 8'h10;

  // Control fields and reset value
  localparam int unsigned CTRL_ACCEPT_POS = 0;
  localparam int unsigned CTRL_FREEZE_POS = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;

  // Status fields
  localparam int unsigned STAT_PINRST_POS = 0;
  localparam int unsigned STAT_UPD_POS    = 1;
  localparam int unsigned STAT_BCAST_POS  = 2;
  localparam int unsigned STAT_ADDR_LSB   = 8;
  localparam int unsigned STAT_CNT_LSB    = 16;
  localparam int unsigned CNT_W           = 16;

  // Entry readback field positions
  localparam int unsigned ENTRY_RANK2_LSB = 8;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : xpt_prog_pkg
`default_nettype wire

/* File: design/xpt_fall_detect.sv */
// Falling-edge detector for a strobe pin sampled on the system clock
`default_nettype none
module xpt_fall_detect (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic level_n,
  output logic      fell
);
  logic prev_r;

  // Idle level is high, so reset to high; a pin already low at reset release reports an edge at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= level_n;
    end
  end

  assign fell = prev_r & ~level_n;
endmodule // xpt_fall_detect
`default_nettype wire

/* File: design/xpt_ahb_slave.sv */
// Zero-wait AHB-Lite slave front end for the programming block registers
`default_nettype none
module xpt_ahb_slave
  import xpt_prog_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_value,
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata
);
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       take;

  // Single word transfers only; hsize is accepted but not checked
  assign take      = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign rd_addr   = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase captured for a write in the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Read data fetched at the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_value;
    end
  end

  assign reg_wr    = wr_pend_r;
  assign reg_addr  = wr_addr_r;
  assign reg_wdata = hwdata;
endmodule // xpt_ahb_slave
`default_nettype wire

/* File: tb/xpt_ctrl_model.sv */
// Behavioural external controller that drives the parallel programming pins
`default_nettype none
module xpt_ctrl_model
  import xpt_prog_pkg::*;
(
  input  wire logic         hclk,
  output logic              chip_select_n,
  output logic              serial_parallel_select,
  output logic              serial_clk_n,
  output logic              write_strobe_n,
  output logic [ADDR_W-1:0] output_address,
  output logic              output_enable_bit,
  output logic [SEL_W-1:0]  input_select,
  output logic              update_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: selected, parallel mode, serial clock parked, update held off
  initial begin
    chip_select_n          = 1'b0;
    serial_parallel_select = 1'b1;
    serial_clk_n           = 1'b1;
    write_strobe_n         = 1'b1;
    update_n               = 1'b1;
    output_address         = 4'h0;
    output_enable_bit      = 1'b0;
    input_select           = 4'h0;
  end
  // One strobed write; address and data settle an edge before the fall
  task automatic wr(input logic [3:0] a, input logic en, input logic [3:0] s, input logic bc);
    @(posedge hclk);
    output_address         <= a;
    output_enable_bit      <= en;
    input_select           <= s;
    serial_parallel_select <= !bc;
    @(posedge hclk);
    write_strobe_n <= 1'b0;
    repeat (2) @(posedge hclk);
    write_strobe_n <= 1'b1;
    @(posedge hclk);
    // Hold over: flip the lines so a late sample cannot pass by luck
    output_address         <= ~a;
    output_enable_bit      <= !en;
    input_select           <= ~s;
    serial_parallel_select <= 1'b1;
  endtask
  // Update stays high until the first rank is fully loaded
  task automatic upd(input logic lvl);
    @(posedge hclk);
    update_n <= lvl;
  endtask
  // Chip select, parked low between scenarios
  task automatic sel(input logic lvl);
    @(posedge hclk);
    chip_select_n <= lvl;
  endtask
endmodule // xpt_ctrl_model
`default_nettype wire

/* File: tb/crosspoint_parallel_programming_tb.sv */
// Self-checking testbench for the parallel programming block
`default_nettype none
module crosspoint_parallel_programming_tb;
  import xpt_prog_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, pin_reset_n, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        chip_select_n, serial_parallel_select, serial_clk_n, write_strobe_n;
  logic        output_enable_bit, update_n;
  logic [3:0]  output_address, input_select;
  logic [8:0]  route_enable;
  logic [35:0] route_select;
  logic        r1_en[9], e_en[9], upd_low;
  logic [3:0]  r1_sel[9], e_sel[9];
  int          n_mismatch, check_count;
  assign hready = hreadyout;
  xpt_parallel_prog #(.OUTPUTS(NUM_OUTPUTS)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .chip_select_n,
    .serial_parallel_select, .serial_clk_n, .write_strobe_n, .output_address,
    .output_enable_bit, .input_select, .update_n, .pin_reset_n, .route_enable, .route_select);
  xpt_ctrl_model u_ctl (.hclk, .chip_select_n, .serial_parallel_select, .serial_clk_n,
    .write_strobe_n, .output_address, .output_enable_bit, .input_select, .update_n);
  // Clock at 100 MHz
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Single AHB transfer: hold address phase until hready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk("register read", {4'h0, d & mask}, {4'h0, exp});
  endtask
  // Pin write plus the expected first rank; writes above output 8 land nowhere
  task automatic wrx(input logic [3:0] a, input logic en, input logic [3:0] s, input logic bc);
    u_ctl.wr(a, en, s, bc);
    for (int i = 0; i < 9; i++) begin
      if (bc || a == 4'(i)) begin
        r1_en[i]  = en;
        r1_sel[i] = s;
      end
      if (upd_low) begin
        e_en[i]  = r1_en[i];
        e_sel[i] = r1_sel[i];
      end
    end
  endtask
  task automatic set_upd(input logic low);
    upd_low = low;
    u_ctl.upd(!low);
    if (low) wrx(4'hF, 1'b0, 4'h0, 1'b0);
  endtask
  // Second rank and output register take two edges; four leaves margin
  task automatic chk_routes();
    logic [35:0] v;
    logic [8:0]  e;
    repeat (4) @(posedge hclk);
    v = '0;
    for (int i = 0; i < 9; i++) begin
      e[i] = e_en[i];
      if (e_en[i]) v[4*i+:4] = e_sel[i];
    end
    chk("route_enable", {27'h0, route_enable}, {27'h0, e});
    chk("route_select", route_select, v);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rdchk(CTRL_OFS, 32'hFFFFFFFF, 32'h1);           // Reset value of control
    rdchk(ENTRY0_OFS + 8'h24, 32'hFFFFFFFF, 32'h0); // Unmapped reads zero
    ahb(1'b1, ENABLES_OFS, 32'hFFFFFFFF, d);
    rdchk(ENABLES_OFS, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_power_up();
    wrx(4'h0, 1'b0, 4'hF, 1'b1);
    for (int i = 0; i < 9; i++) wrx(4'(i), !i[0], 4'(i + 3), 1'b0);
    for (int i = 0; i < 9; i++) rdchk(ENTRY0_OFS + 8'(4 * i), 32'h1F, {!i[0], 4'(i + 3)});
    set_upd(1'b1);
    pin_reset_n <= 1'b1;
    chk_routes();
    set_upd(1'b0);
  endtask
  task automatic t_single();
    wrx(4'h3, 1'b1, 4'hA, 1'b0);
    wrx(4'h8, 1'b0, 4'h7, 1'b0);
    chk_routes();
    set_upd(1'b1);
    chk_routes();
    wrx(4'h5, 1'b1, 4'hC, 1'b0);
    chk_routes();
    for (int a = 9; a < 16; a++) wrx(4'(a), 1'b1, 4'h1, 1'b0);
    chk_routes();
  endtask
  task automatic t_pin_reset();
    @(posedge hclk);
    pin_reset_n <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("route_enable", {27'h0, route_enable}, 36'h0);
    pin_reset_n <= 1'b1;
    chk_routes();
  endtask
  task automatic t_bcast();
    wrx(4'h2, 1'b1, 4'h5, 1'b1);
    chk_routes();
    rdchk(ENABLES_OFS, 32'hFFFFFFFF, 32'h1FF);
  endtask
  // Software lock-out, chip select gating and update freeze
  task automatic t_ctrl();
    logic [31:0] d;
    ahb(1'b1, CTRL_OFS, 32'h0, d);
    u_ctl.wr(4'h4, 1'b0, 4'h0, 1'b0);
    chk_routes();
    ahb(1'b1, CTRL_OFS, 32'h1, d);
    u_ctl.sel(1'b1);
    u_ctl.wr(4'h6, 1'b0, 4'h0, 1'b1);
    chk_routes();
    u_ctl.sel(1'b0);
    ahb(1'b1, CTRL_OFS, 32'h3, d);
    upd_low = 1'b0;
    wrx(4'h4, 1'b0, 4'h0, 1'b0);
    chk_routes();
    rdchk(ENTRY0_OFS + 8'h10, 32'h1F1F, 32'h1500);
    ahb(1'b1, CTRL_OFS, 32'h1, d);
    set_upd(1'b1);
    chk_routes();
    rdchk(STATUS_OFS, 32'hFFFF0F07, 32'h000F0402);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize, upd_low} = '0;
    pin_reset_n = 1'b0; // Outputs held off from power-up until programmed
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_power_up();
    t_single();
    t_pin_reset();
    t_bcast();
    t_ctrl();
    close_out();
  end
endmodule // crosspoint_parallel_programming_tb
`default_nettype wire
